// [sar_adc_sequencer.sv]
// Purpose: Sequencing of a 10-bit successive-approximation converter
// Assumes: Analog stage turns trial_code n into n/1024 of reference and
//          answers trial_below within one step period
// Notes:   Comparator input passes two flip-flops before use; a start in
//          any state restarts; a completion beats a same-cycle request
//          clear
`timescale 1ns/1ps
`include "sar_adc_params.svh"
module sar_adc_sequencer #(
  parameter int WIDTH = `ADC_BITS
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // Software side
  input  wire logic                   done_write,
  input  wire logic                   done_wdata,
  input  wire logic                   irq_flag_clear,
  output logic                        done_flag,
  output logic                        irq_flag,
  output logic                        irq_pulse,
  output logic        [WIDTH-1:0]     result,
  // Analog stage
  input  wire logic                   trial_below,
  output logic        [WIDTH-1:0]     trial_code,
  output sar_adc_pkg::adc_state_t     state_out
);
  import sar_adc_pkg::*;

  // Refuse widths the step timing and constants were not built for
  if (WIDTH != `ADC_BITS) begin : g_width_check
    $error("sar_adc_sequencer serves only the documented width");
  end

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------
  // trial_below is asynchronous to clk; only sync2_q feeds the logic
  logic sync1_q;
  logic sync2_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= trial_below;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  adc_state_t       state_q, state_d;
  logic [5:0]       cnt_q, cnt_d;
  logic [5:0]       sub_q, sub_d;
  logic [WIDTH-1:0] mask_q, mask_d;
  logic [WIDTH-1:0] code_q, code_d;
  logic [WIDTH-1:0] trial_q, trial_d;
  logic [WIDTH-1:0] result_q, result_d;
  logic             done_q, done_d;
  logic             irqf_q, irqf_d;
  logic             irqp_q, irqp_d;
  logic [WIDTH-1:0] step_trial;
  logic [WIDTH-1:0] step_code;
  logic             start;
  logic             finish;
  logic [WIDTH-1:0] final_code;

  // Completion falls due when the count since start reaches the total
  function automatic logic conv_due(input logic [5:0] count);
    return count == 6'(`ADC_CONV_CYCLES);
  endfunction

  assign start = done_write && !done_wdata;

  sar_step #(
    .WIDTH (WIDTH)
  ) u_step (
    .code_in     (code_q),
    .bit_mask    (mask_q),
    .trial_below (sync2_q),
    .trial_code  (step_trial),
    .code_out    (step_code)
  );

  // Start edge clears, the next edge shows the top trial, and each bit
  // then holds its trial for ADC_STEP_CYCLES so the two-flop comparator
  // path settles; the tenth decision lands on the completion count
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    sub_d    = sub_q;
    mask_d   = mask_q;
    code_d   = code_q;
    trial_d  = trial_q;
    finish     = 1'b0;
    final_code = code_q;
    if (start) begin
      state_d  = st_clear;
      cnt_d    = `ADC_CNT_ONE;
      sub_d    = `ADC_CNT_ZERO;
      // A start in any state begins again from the top bit
      code_d   = `ADC_ZERO;
      trial_d  = `ADC_ZERO;
      mask_d   = {1'b1, {(WIDTH-1){1'b0}}};
    end else begin
      if (state_q != st_idle) begin
        cnt_d = cnt_q + `ADC_CNT_ONE;
      end
      case (state_q)
        st_idle: begin
        end
        st_clear: begin
          state_d = st_step;
          trial_d = step_trial;
        end
        st_step: begin
          sub_d = sub_q + `ADC_CNT_ONE;
          if (sub_q == 6'(`ADC_STEP_CYCLES - 1)) begin
            sub_d  = `ADC_CNT_ZERO;
            code_d = step_code;
            if (mask_q[0]) begin
              // Last decision: finish now if the count is already due
              trial_d = step_code;
              if (conv_due(cnt_q)) begin
                state_d    = st_idle;
                finish     = 1'b1;
                final_code = step_code;
              end else begin
                state_d = st_hold;
              end
            end else begin
              mask_d  = mask_q >> 1;
              trial_d = step_code | (mask_q >> 1);
            end
          end
        end
        st_hold: begin
          // Waits out the rest of the fixed conversion time
          if (conv_due(cnt_q)) begin
            state_d    = st_idle;
            finish     = 1'b1;
            final_code = code_q;
          end
        end
        default: begin
          state_d = st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q  <= st_idle;
      cnt_q    <= `ADC_CNT_ZERO;
      sub_q    <= `ADC_CNT_ZERO;
      mask_q   <= `ADC_ZERO;
      code_q   <= `ADC_ZERO;
      trial_q  <= `ADC_ZERO;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      sub_q    <= sub_d;
      mask_q   <= mask_d;
      code_q   <= code_d;
      trial_q  <= trial_d;
    end
  end

  // ----------------------------------------------------------------
  // Completion flags and result register
  // ----------------------------------------------------------------
  always_comb begin
    result_d = result_q;
    done_d   = done_q;
    irqf_d   = irqf_q;
    irqp_d   = 1'b0;
    // A clear loses to a completion in the same cycle
    if (irq_flag_clear) begin
      irqf_d = 1'b0;
    end
    // Result register only moves at start and at completion
    if (start) begin
      result_d = `ADC_ZERO;
      done_d   = 1'b0;
    end else if (finish) begin
      result_d = final_code;
      done_d   = 1'b1;
      irqf_d   = 1'b1;
      irqp_d   = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      result_q <= `ADC_ZERO;
      done_q   <= 1'b0;
      irqf_q   <= 1'b0;
      irqp_q   <= 1'b0;
    end else begin
      result_q <= result_d;
      done_q   <= done_d;
      irqf_q   <= irqf_d;
      irqp_q   <= irqp_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a flop; nothing combinational reaches a port
  assign done_flag  = done_q;
  assign irq_flag   = irqf_q;
  assign irq_pulse  = irqp_q;
  assign result     = result_q;
  assign trial_code = trial_q;
  assign state_out  = state_q;
endmodule

// [sar_adc_params.svh]
// Purpose: Constants for the successive-approximation sequencer
// Assumes: 200 MHz system clock
// Notes:   Types live in sar_adc_pkg
// How it works
// - Writing zero to done flag starts conversion
// - Result cleared to zero at start
// - Set bit under test, present trial code
// - Keep bit if trial below input, else clear
// - Ten steps, most to least significant bit
// - Decided bits kept, lower bits stay zero
// - Completes 61 clocks after start, stores result
// - Completion sets done, pulses and sets request
// - Trial code n selects n/1024 of reference
`ifndef SAR_ADC_PARAMS_SVH
`define SAR_ADC_PARAMS_SVH
`define ADC_BITS        10
`define ADC_CONV_CYCLES 61
`define ADC_STEP_CYCLES 6
`define ADC_ZERO        10'h000
`define ADC_CNT_ZERO    6'h00
`define ADC_CNT_ONE     6'h01
`endif

// [sar_adc_pkg.sv]
// Purpose: Types for the successive-approximation sequencer
// Assumes: Nothing
// Notes:   Constants live in sar_adc_params.svh
package sar_adc_pkg;
  typedef enum logic [1:0] {
    st_idle,
    st_clear,
    st_step,
    st_hold
  } adc_state_t;
endpackage

// [sar_step.sv]
// Purpose: One successive-approximation decision on a code word
// Assumes: Bit mask has exactly one bit set
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "sar_adc_params.svh"
module sar_step #(
  parameter int WIDTH = `ADC_BITS
) (
  // Code in and bit under test
  input  wire logic [WIDTH-1:0] code_in,
  input  wire logic [WIDTH-1:0] bit_mask,
  // Comparator answer: trial below input
  input  wire logic             trial_below,
  // Codes out
  output logic      [WIDTH-1:0] trial_code,
  output logic      [WIDTH-1:0] code_out
);
  always_comb begin
    trial_code = code_in | bit_mask;
    if (trial_below) begin
      code_out = trial_code;
    end else begin
      code_out = code_in & ~bit_mask;
    end
  end
endmodule

// [sar_adc_asserts.sv]
// Purpose: Port assertions for the sequencer
// Assumes: Start is done_write high with done_wdata low
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
module sar_adc_asserts #(parameter int WIDTH = 10) (
  input wire logic             clk, reset, done_write, done_wdata,
  input wire logic             irq_flag_clear, done_flag,
  input wire logic             irq_flag, irq_pulse,
  input wire logic [WIDTH-1:0] result, trial_code
);
  logic [7:0] cnt_q, cnt_d;
  wire        st = done_write && !done_wdata;
  // Cycles since the last start, saturating
  always_comb cnt_d = st ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hff};
  always_ff @(posedge clk) cnt_q <= reset ? 8'hff : cnt_d;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_start_clears: assert property (
    st |=> !done_flag && result == '0) else $error("start not seen");
  a_first_trial: assert property (
    st ##1 !st |=> trial_code == 10'h200) else $error("bad first trial");
  a_conv_time: assert property (
    $rose(irq_pulse) |-> cnt_q == 8'h3d)
    else $error("conversion time off");
  a_done_irq: assert property (
    $rose(done_flag) |-> irq_pulse && irq_flag) else $error("done alone");
  a_pulse_once: assert property (
    irq_pulse |=> !irq_pulse) else $error("pulse too long");
  a_irq_sticky: assert property (
    irq_flag && !irq_flag_clear |=> irq_flag) else $error("flag lost");
  a_irq_clear: assert property (
    irq_flag_clear ##1 !irq_pulse |-> !irq_flag) else $error("no clear");
  a_result_hold: assert property (
    !$past(st) && !irq_pulse |-> $stable(result))
    else $error("result moved");
  a_done_hold: assert property (
    done_flag && !st |=> done_flag) else $error("done dropped");
  cover property (st);
  cover property (irq_pulse);
  cover property (irq_flag_clear && irq_flag);
endmodule

// [sar_comparator.sv]
// Purpose: Analog comparator and divider model
// Assumes: Level code n stands for n/1024 of reference
// Notes:   Input sits half a step above its code, so ties never occur
`timescale 1ns/1ps
module sar_comparator (
  input wire logic [9:0] trial_code, analog_input_level,
  output logic           trial_below
);
  assign trial_below = trial_code <= analog_input_level;
endmodule

// [sar_adc_sequencer_tb.sv]
// Purpose: Self-checking bench for the sequencer
// Assumes: Comparator model on the analog side
// Notes:   Driver queues expected codes, monitor checks on irq_pulse
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin \
  n_mismatch++; $display("mismatch t=%0t value differs", $time); end end
module sar_adc_sequencer_tb;
  logic       clk = 0, reset = 1, done_write = 0, done_wdata = 0;
  logic       irq_flag_clear = 0, trial_below, done_flag, irq_flag;
  logic       irq_pulse;
  logic [9:0] result, trial_code, level = 10'h000, q[$];
  int         n_mismatch = 0, checks_done = 0, seed = 82882, i;
  logic [9:0] fixed_lv [6] = '{10'h000, 10'h3ff, 10'h2aa, 10'h155,
                               10'h200, 10'h1ff};
  sar_adc_pkg::adc_state_t state_out;
  always #2.5 clk = ~clk;
  sar_adc_sequencer sar_adc_sequencer_inst (.clk(clk), .reset(reset),
    .done_write(done_write), .done_wdata(done_wdata),
    .irq_flag_clear(irq_flag_clear), .done_flag(done_flag),
    .irq_flag(irq_flag), .irq_pulse(irq_pulse), .result(result),
    .trial_below(trial_below), .trial_code(trial_code),
    .state_out(state_out));
  sar_comparator sar_comparator_inst (.trial_code(trial_code),
    .analog_input_level(level), .trial_below(trial_below));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic v, input logic [9:0] lv);
    @(posedge clk);
    level <= lv;
    done_write <= 1;
    done_wdata <= v;
    @(posedge clk);
    done_write <= 0;
  endtask
  task automatic conv(input logic [9:0] lv);
    wr(1'b0, lv);
    q.push_back(lv);
    @(negedge clk);
    for (i = 0; i < 100 && irq_pulse !== 1'b1; i++) @(negedge clk);
    `CHK(i, 61)
    @(posedge clk);
    irq_flag_clear <= 1;
    @(posedge clk);
    irq_flag_clear <= 0;
    @(negedge clk);
    `CHK(irq_flag, 1'b0)
    `CHK(done_flag, 1'b1)
  endtask
  // Monitor: each completion takes the oldest expected code
  always @(negedge clk) begin
    if (irq_pulse === 1'b1) begin
      `CHK(state_out, sar_adc_pkg::st_idle)
      `CHK(q.size() > 0, 1'b1)
      `CHK(result, q.pop_front())
      `CHK(done_flag, 1'b1)
      `CHK(irq_flag, 1'b1)
    end
  end
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (12) @(posedge clk);
    reset <= 0;
    foreach (fixed_lv[j]) conv(fixed_lv[j]);
    repeat (4) conv(10'($random(seed)));
    // Restart mid-run, with a write of one that must be ignored
    wr(1'b0, 10'h0f0);
    repeat (20) @(posedge clk);
    wr(1'b1, 10'h0f0);
    `CHK(done_flag, 1'b0)
    conv(10'h30f);
    // Writing one while idle starts nothing and leaves the flag set
    wr(1'b1, 10'h0f0);
    repeat (70) @(negedge clk);
    `CHK(done_flag, 1'b1)
    `CHK(irq_flag, 1'b0)
    report_and_stop();
  end
endmodule
bind sar_adc_sequencer sar_adc_asserts #(.WIDTH(WIDTH)) chk (.clk(clk),
  .reset(reset), .done_write(done_write), .done_wdata(done_wdata),
  .irq_flag_clear(irq_flag_clear), .done_flag(done_flag),
  .irq_flag(irq_flag), .irq_pulse(irq_pulse), .result(result),
  .trial_code(trial_code));
